//--- rtl/sld_defines.svh
`ifndef SLD_DEFINES_SVH
`define SLD_DEFINES_SVH

// ****************************************
// Geometry
// ****************************************
`define SLD_NUM_SEG         40
`define SLD_LOW_GROUP       16
`define SLD_DIV_W           15
`define SLD_ADDR_W          8
`define SLD_FIFO_DEPTH      4
`define SLD_EV_W            3

// ****************************************
// Timing
// ****************************************
`define SLD_REF_HZ          20000000
`define SLD_OSC_HZ          32000
`define SLD_OSC_HALF_CYC    (`SLD_REF_HZ / (2 * `SLD_OSC_HZ))
`define SLD_OSC_CNT_W       9

// ****************************************
// Divider taps
// ****************************************
`define SLD_DISP_TAP_LSB    3
`define SLD_DISP_TAP_MAX    4
`define SLD_BLINK_TAP_LSB   12
`define SLD_BLINK_TAP_MAX   2

// ****************************************
// Queued event word
// ****************************************
`define SLD_EV_BIT          0
`define SLD_EV_SHIFT        1
`define SLD_EV_LOAD         2

// ****************************************
// Register offsets
// ****************************************
`define SLD_REG_CTRL        8'h00
`define SLD_REG_SHIFT_LO    8'h04
`define SLD_REG_SHIFT_HI    8'h08
`define SLD_REG_LATCH_LO    8'h0C
`define SLD_REG_LATCH_HI    8'h10
`define SLD_REG_STATUS      8'h14

// ****************************************
// Field positions and reset values
// ****************************************
`define SLD_CTRL_W          8
`define SLD_CTRL_RST        8'h00
`define SLD_ST_EMPTY        0
`define SLD_ST_FULL         1
`define SLD_ST_BLINK        2
`define SLD_ST_OVERFLOW     3

`endif

//--- rtl/sld_fifo.sv
module sld_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wptr;
    logic [PTR_W-1:0]            rptr;
    logic [CNT_W-1:0]            count;
  } sld_fifo_state_t;

  sld_fifo_state_t q_ff;
  sld_fifo_state_t nxt_q;
  logic            push;
  logic            pop;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
  endfunction

  assign in_ready  = (q_ff.count != CNT_W'(DEPTH));
  assign out_valid = (q_ff.count != '0);
  assign out_data  = q_ff.mem[q_ff.rptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    nxt_q = q_ff;
    if (push) begin
      nxt_q.mem[q_ff.wptr] = in_data;
      nxt_q.wptr           = ptr_inc(q_ff.wptr);
    end
    if (pop) begin
      nxt_q.rptr = ptr_inc(q_ff.rptr);
    end
    if (push && !pop) begin
      nxt_q.count = CNT_W'(q_ff.count + 1'b1);
    end else if (pop && !push) begin
      nxt_q.count = CNT_W'(q_ff.count - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule

//--- rtl/sld_pkg.sv
`include "sld_defines.svh"

package sld_pkg;

  typedef struct packed {
    logic [1:0] blink_tap;
    logic       blink_int;
    logic [2:0] disp_tap;
    logic       disp_int;
    logic       freeze;
  } sld_ctrl_t;

  typedef struct packed {
    logic                         rst_meta;
    logic                         rst_done;
  } sld_rst_t;

  typedef struct packed {
    logic [`SLD_NUM_SEG-1:0]      shift;
    logic [`SLD_NUM_SEG-1:0]      latch;
    logic [`SLD_DIV_W-1:0]        div;
    logic [`SLD_OSC_CNT_W-1:0]    osc_cnt;
    logic                         osc;
    logic                         sclk_d;
    logic                         load_d;
    logic                         fin_d;
    logic [`SLD_NUM_SEG-1:0]      seg;
    logic                         com_a;
    logic                         com_b;
    logic                         overflow;
    sld_ctrl_t                    ctrl;
    logic [31:0]                  rdata;
  } sld_state_t;

endpackage

//--- rtl/sld_static_lcd.sv
// Implementation choices: the address map and strobed register access.
`include "sld_defines.svh"

module sld_static_lcd
  import sld_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire logic [`SLD_ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  input  wire logic                    serial_data_in,
  input  wire logic                    shift_clock,
  input  wire logic                    load_strobe,
  output logic                         serial_data_out,
  output logic                         serial_ready,
  input  wire logic                    osc_enable_n,
  output logic                         osc_out,
  input  wire logic                    core_clock_in,
  output logic      [4:0]              div_disp_out,
  output logic      [2:0]              div_blink_out,
  input  wire logic                    display_clock_in,
  input  wire logic                    blink_clock_in,
  input  wire logic                    blink_enable_n,
  input  wire logic                    seg_group_low_enable_n,
  input  wire logic                    seg_group_high_enable_n,
  input  wire logic                    common_a_enable_n,
  input  wire logic                    common_b_enable_n,
  output logic      [`SLD_NUM_SEG-1:0] segment_out,
  output logic                         common_a_out,
  output logic                         common_b_out
);

  import sld_pkg::*;

  localparam int NUM_IN = 12;

  // ****************************************
  // Reset release
  // ****************************************
  sld_rst_t   rst_ff;
  sld_rst_t   nxt_rst;
  logic       rst_n;

  always_comb begin
    nxt_rst          = rst_ff;
    nxt_rst.rst_meta = 1'b1;
    nxt_rst.rst_done = rst_ff.rst_meta;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_ff <= '0;
    end else begin
      rst_ff <= nxt_rst;
    end
  end

  assign rst_n = rst_ff.rst_done;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [NUM_IN-1:0] pins_raw;
  logic [NUM_IN-1:0] pins_s;
  logic              s_din;
  logic              s_sclk;
  logic              s_load;
  logic              s_fin;
  logic              s_display_clock_in;
  logic              s_bclk;
  logic              s_oen_n;
  logic              s_ben_n;
  logic              s_sen_lo_n;
  logic              s_sen_hi_n;
  logic              s_cena_n;
  logic              s_cenb_n;

  assign pins_raw = {serial_data_in, shift_clock, load_strobe, core_clock_in,
                     display_clock_in, blink_clock_in, osc_enable_n, blink_enable_n,
                     seg_group_low_enable_n, seg_group_high_enable_n,
                     common_a_enable_n, common_b_enable_n};

  sld_sync #(
    .WIDTH    (NUM_IN)
  ) u_sync (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  assign {s_din, s_sclk, s_load, s_fin, s_display_clock_in, s_bclk, s_oen_n, s_ben_n,
          s_sen_lo_n, s_sen_hi_n, s_cena_n, s_cenb_n} = pins_s;

  // ****************************************
  // State
  // ****************************************
  sld_state_t q_ff;
  sld_state_t nxt_q;

  logic                     sclk_rise;
  logic                     load_rise;
  logic                     fin_rise;
  logic                     ev_valid;
  logic                     ev_ready;
  logic [`SLD_EV_W-1:0]     ev_data;
  logic                     q_valid;
  logic                     q_ready;
  logic [`SLD_EV_W-1:0]     q_data;
  logic                     fifo_empty;
  logic                     disp_clk;
  logic                     blink_clk;
  logic                     blank;

  // Selects one divider stage, clamped to the highest legal tap
  function automatic logic tap_pick(input logic [`SLD_DIV_W-1:0] div,
                                    input int unsigned           lsb,
                                    input int unsigned           sel,
                                    input int unsigned           max);
    int unsigned idx;
    idx = lsb + ((sel > max) ? max : sel);
    return div[idx];
  endfunction

  // ****************************************
  // Serial events into the queue
  // ****************************************
  assign sclk_rise = s_sclk & ~q_ff.sclk_d;
  assign load_rise = s_load & ~q_ff.load_d;
  assign fin_rise  = s_fin & ~q_ff.fin_d;

  // Shift is applied before load when both edges land together
  assign ev_valid                = sclk_rise | load_rise;
  assign ev_data[`SLD_EV_BIT]    = s_din;
  assign ev_data[`SLD_EV_SHIFT]  = sclk_rise;
  assign ev_data[`SLD_EV_LOAD]   = load_rise;

  // Freeze holds queued events so software can read a stable snapshot
  assign q_ready      = ~q_ff.ctrl.freeze;
  assign fifo_empty   = ~q_valid;
  assign serial_ready = ev_ready;

  sld_fifo #(
    .WIDTH     (`SLD_EV_W),
    .DEPTH     (`SLD_FIFO_DEPTH)
  ) u_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (ev_valid),
    .in_ready  (ev_ready),
    .in_data   (ev_data),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );

  // ****************************************
  // Clock selection and blink
  // ****************************************
  assign disp_clk  = q_ff.ctrl.disp_int ?
                     tap_pick(q_ff.div, `SLD_DISP_TAP_LSB, q_ff.ctrl.disp_tap,
                              `SLD_DISP_TAP_MAX) : s_display_clock_in;
  assign blink_clk = q_ff.ctrl.blink_int ?
                     tap_pick(q_ff.div, `SLD_BLINK_TAP_LSB, q_ff.ctrl.blink_tap,
                              `SLD_BLINK_TAP_MAX) : s_bclk;
  assign blank     = ~s_ben_n & blink_clk;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic seg_en;
    logic lit;
    nxt_q        = q_ff;
    seg_en       = 1'b0;
    lit          = 1'b0;
    nxt_q.sclk_d = s_sclk;
    nxt_q.load_d = s_load;
    nxt_q.fin_d  = s_fin;

    if (q_valid && q_ready) begin
      if (q_data[`SLD_EV_SHIFT]) begin
        nxt_q.shift = {q_ff.shift[`SLD_NUM_SEG-2:0], q_data[`SLD_EV_BIT]};
      end
      if (q_data[`SLD_EV_LOAD]) begin
        nxt_q.latch = nxt_q.shift;
      end
    end

    if (fin_rise) begin
      nxt_q.div = `SLD_DIV_W'(q_ff.div + 1'b1);
    end

    if (!s_oen_n) begin
      if (q_ff.osc_cnt == `SLD_OSC_CNT_W'(`SLD_OSC_HALF_CYC - 1)) begin
        nxt_q.osc_cnt = '0;
        nxt_q.osc     = ~q_ff.osc;
      end else begin
        nxt_q.osc_cnt = `SLD_OSC_CNT_W'(q_ff.osc_cnt + 1'b1);
      end
    end else begin
      nxt_q.osc_cnt = '0;
      nxt_q.osc     = 1'b0;
    end

    for (int i = 0; i < `SLD_NUM_SEG; i++) begin
      seg_en       = (i < `SLD_LOW_GROUP) ? ~s_sen_lo_n : ~s_sen_hi_n;
      lit          = q_ff.latch[i] & ~blank;
      nxt_q.seg[i] = seg_en & (lit ? disp_clk : ~disp_clk);
    end

    nxt_q.com_a = ~s_cena_n & ~disp_clk;
    nxt_q.com_b = ~s_cenb_n & ~disp_clk;

    // Register writes
    if (reg_wr) begin
      if (reg_addr == `SLD_REG_CTRL) begin
        nxt_q.ctrl = sld_ctrl_t'(reg_wdata[`SLD_CTRL_W-1:0]);
      end else if (reg_addr == `SLD_REG_STATUS) begin
        if (reg_wdata[`SLD_ST_OVERFLOW]) begin
          nxt_q.overflow = 1'b0;
        end
      end
    end

    // Lost event sets after any clear, so it wins
    if (ev_valid && !ev_ready) begin
      nxt_q.overflow = 1'b1;
    end

    // Register reads, answer stands one cycle only
    nxt_q.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == `SLD_REG_CTRL) begin
        nxt_q.rdata = {24'h000000, q_ff.ctrl};
      end else if (reg_addr == `SLD_REG_SHIFT_LO) begin
        nxt_q.rdata = q_ff.shift[31:0];
      end else if (reg_addr == `SLD_REG_SHIFT_HI) begin
        nxt_q.rdata = {24'h000000, q_ff.shift[`SLD_NUM_SEG-1:32]};
      end else if (reg_addr == `SLD_REG_LATCH_LO) begin
        nxt_q.rdata = q_ff.latch[31:0];
      end else if (reg_addr == `SLD_REG_LATCH_HI) begin
        nxt_q.rdata = {24'h000000, q_ff.latch[`SLD_NUM_SEG-1:32]};
      end else if (reg_addr == `SLD_REG_STATUS) begin
        nxt_q.rdata[`SLD_ST_EMPTY]    = fifo_empty;
        nxt_q.rdata[`SLD_ST_FULL]     = ~ev_ready;
        nxt_q.rdata[`SLD_ST_BLINK]    = ~s_ben_n;
        nxt_q.rdata[`SLD_ST_OVERFLOW] = q_ff.overflow;
      end else begin
        nxt_q.rdata = '0;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff      <= '0;
      q_ff.ctrl <= sld_ctrl_t'(`SLD_CTRL_RST);
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata       = q_ff.rdata;
  assign serial_data_out = q_ff.shift[`SLD_NUM_SEG-1];
  assign osc_out         = q_ff.osc;
  assign div_disp_out    = q_ff.div[`SLD_DISP_TAP_LSB +: 5];
  assign div_blink_out   = q_ff.div[`SLD_BLINK_TAP_LSB +: 3];
  assign segment_out     = q_ff.seg;
  assign common_a_out    = q_ff.com_a;
  assign common_b_out    = q_ff.com_b;

endmodule

//--- rtl/sld_sync.sv
module sld_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sld_sync_state_t;

  sld_sync_state_t q_ff;
  sld_sync_state_t nxt_q;

  always_comb begin
    nxt_q        = q_ff;
    nxt_q.meta   = async_in;
    nxt_q.stable = q_ff.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign sync_out = q_ff.stable;

endmodule

//--- tb/sld_host_model.sv
module sld_host_model (
  input  wire logic ref_clk,
  output logic      serial_data_in,
  output logic      shift_clock,
  output logic      load_strobe
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    serial_data_in = 1'b0;
    shift_clock = 1'b0;
    load_strobe = 1'b0;
  end

  // Ten cycles keeps every pin phase above the minimum width
  task automatic phase();
    repeat (10) @(posedge ref_clk);
  endtask

  task automatic shift_bit(input logic b);
    @(posedge ref_clk);
    serial_data_in <= b;
    phase();
    shift_clock <= 1'b1;
    phase();
    shift_clock <= 1'b0;
    phase();
  endtask

  task automatic load();
    @(posedge ref_clk);
    load_strobe <= 1'b1;
    phase();
    load_strobe <= 1'b0;
    phase();
  endtask

  task automatic send(input logic [39:0] v);
    for (int i = 39; i >= 0; i--) begin
      shift_bit(v[i]);
    end
  endtask
endmodule

//--- tb/sld_static_lcd_chk.sv
`include "sld_defines.svh"

module sld_static_lcd_chk (
  input wire logic                    ref_clk,
  input wire logic                    resetn,
  input wire logic                    display_clock_in,
  input wire logic                    blink_clock_in,
  input wire logic                    blink_enable_n,
  input wire logic                    seg_group_low_enable_n,
  input wire logic                    seg_group_high_enable_n,
  input wire logic                    common_a_enable_n,
  input wire logic                    common_b_enable_n,
  input wire logic                    osc_enable_n,
  input wire logic                    osc_out,
  input wire logic [`SLD_NUM_SEG-1:0] segment_out,
  input wire logic                    common_a_out,
  input wire logic                    common_b_out
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // ****************************************
  // Pin relations, pins lag by a few cycles
  // ****************************************
  property p_rst_clear;
    disable iff (1'b0) !resetn |-> segment_out == 0 && !common_a_out && !common_b_out;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("outputs not cleared in reset");
  property p_com_a_off;
    common_a_enable_n [*8] |-> !common_a_out;
  endproperty
  a_com_a_off: assert property (p_com_a_off)
    else $error("common a not low while disabled");
  property p_com_b_off;
    common_b_enable_n [*8] |-> !common_b_out;
  endproperty
  a_com_b_off: assert property (p_com_b_off)
    else $error("common b not low while disabled");
  property p_com_a_inv;
    (!common_a_enable_n && $stable(display_clock_in)) [*8] |-> common_a_out == !display_clock_in;
  endproperty
  a_com_a_inv: assert property (p_com_a_inv)
    else $error("common a not inverse of display clock");
  property p_low_off;
    seg_group_low_enable_n [*8] |-> segment_out[`SLD_LOW_GROUP-1:0] == 0;
  endproperty
  a_low_off: assert property (p_low_off)
    else $error("low segment group not held low");
  property p_high_off;
    seg_group_high_enable_n [*8] |-> segment_out[`SLD_NUM_SEG-1:`SLD_LOW_GROUP] == 0;
  endproperty
  a_high_off: assert property (p_high_off)
    else $error("high segment group not held low");
  property p_osc_off;
    osc_enable_n [*8] |=> !osc_out;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator runs while disabled");
  property p_blink_off;
    (!blink_enable_n && blink_clock_in && display_clock_in) [*8] |-> segment_out == 0;
  endproperty
  a_blink_off: assert property (p_blink_off)
    else $error("lit segments not blanked in blink phase");
endmodule

bind sld_static_lcd sld_static_lcd_chk u_chk (
  .ref_clk,
  .resetn,
  .display_clock_in,
  .blink_clock_in,
  .blink_enable_n,
  .seg_group_low_enable_n,
  .seg_group_high_enable_n,
  .common_a_enable_n,
  .common_b_enable_n,
  .osc_enable_n,
  .osc_out,
  .segment_out,
  .common_a_out,
  .common_b_out
);

//--- tb/sld_static_lcd_tb.sv
`include "sld_defines.svh"

module sld_static_lcd_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sld_pkg::*;

  localparam int          DIV_EDGES = 4232;
  localparam logic [39:0] PAT_A     = 40'hA5C30F963C;
  localparam logic [39:0] PAT_B     = 40'h5A3CF069C3;

  logic ref_clk = 1'b0, resetn = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic serial_data_in, shift_clock, load_strobe, serial_data_out, serial_ready;
  logic osc_enable_n = 1'b1, osc_out, core_clock_in = 1'b0, display_clock_in = 1'b1;
  logic blink_clock_in = 1'b0, blink_enable_n = 1'b1, common_a_out, common_b_out;
  logic seg_group_low_enable_n = 1'b0, seg_group_high_enable_n = 1'b0;
  logic common_a_enable_n = 1'b0, common_b_enable_n = 1'b0, o;
  logic [4:0] div_disp_out;
  logic [2:0] div_blink_out;
  logic [39:0] segment_out;
  int bad_count = 0, cmp_count = 0, cyc = 0, k;

  sld_static_lcd dut (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .serial_data_in, .shift_clock, .load_strobe, .serial_data_out,
    .serial_ready, .osc_enable_n, .osc_out, .core_clock_in, .div_disp_out,
    .div_blink_out, .display_clock_in, .blink_clock_in, .blink_enable_n,
    .seg_group_low_enable_n, .seg_group_high_enable_n, .common_a_enable_n,
    .common_b_enable_n, .segment_out, .common_a_out, .common_b_out);
  sld_host_model host (.ref_clk, .serial_data_in, .shift_clock, .load_strobe);

  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic settle();
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(40'(reg_rdata), 40'(e));
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    // Real falling edge so the asynchronous reset acts before the first clock
    resetn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    settle();
    chk(segment_out, 40'h0);
    rd(`SLD_REG_SHIFT_LO, 32'h0);
    rd(`SLD_REG_LATCH_HI, 32'h0);
    rd(8'h20, 32'h0);
    $display("reset test done");
    host.send(PAT_A);
    host.load();
    settle();
    rd(`SLD_REG_LATCH_LO, PAT_A[31:0]);
    rd(`SLD_REG_LATCH_HI, 32'(PAT_A[39:32]));
    chk(segment_out, PAT_A);
    display_clock_in <= 1'b0;
    settle();
    chk(segment_out, ~PAT_A);
    chk({common_a_out, common_b_out}, 40'h3);
    $display("load test done");
    for (int i = 0; i < 40; i++) begin
      host.shift_bit(PAT_B[39-i]);
      chk(serial_data_out, (i < 39) ? PAT_A[38-i] : PAT_B[39]);
    end
    rd(`SLD_REG_SHIFT_LO, PAT_B[31:0]);
    rd(`SLD_REG_LATCH_LO, PAT_A[31:0]);
    $display("chain test done");
    seg_group_low_enable_n <= 1'b1;
    common_a_enable_n <= 1'b1;
    settle();
    chk(segment_out, {~PAT_A[39:16], 16'h0});
    chk({common_a_out, common_b_out}, 40'h1);
    seg_group_high_enable_n <= 1'b1;
    common_b_enable_n <= 1'b1;
    settle();
    chk(segment_out, 40'h0);
    chk({common_a_out, common_b_out}, 40'h0);
    seg_group_low_enable_n <= 1'b0;
    seg_group_high_enable_n <= 1'b0;
    display_clock_in <= 1'b1;
    blink_enable_n <= 1'b0;
    blink_clock_in <= 1'b1;
    settle();
    chk(segment_out, 40'h0);
    rd(`SLD_REG_STATUS, 32'h5);
    blink_clock_in <= 1'b0;
    settle();
    chk(segment_out, PAT_A);
    blink_enable_n <= 1'b1;
    blink_clock_in <= 1'b1;
    settle();
    chk(segment_out, PAT_A);
    $display("enable test done");
    wr(`SLD_REG_CTRL, 32'h1);
    repeat (5) host.shift_bit(1'b1);
    chk(serial_ready, 40'h0);
    rd(`SLD_REG_STATUS, 32'hA);
    wr(`SLD_REG_CTRL, 32'h0);
    settle();
    wr(`SLD_REG_STATUS, 32'h8);
    rd(`SLD_REG_STATUS, 32'h1);
    rd(`SLD_REG_SHIFT_LO, {PAT_B[27:0], 4'hF});
    $display("queue test done");
    chk(osc_out, 40'h0);
    osc_enable_n <= 1'b0;
    for (int n = 0; n < 2; n++) begin
      k = 0;
      o = osc_out;
      while (osc_out === o && k < 1000) begin
        @(posedge ref_clk);
        k++;
      end
    end
    chk(40'(k), 40'(`SLD_OSC_HALF_CYC));
    osc_enable_n <= 1'b1;
    $display("oscillator test done");
    @(posedge ref_clk);
    for (int i = 0; i < DIV_EDGES; i++) begin
      core_clock_in <= 1'b1;
      repeat (8) @(posedge ref_clk);
      core_clock_in <= 1'b0;
      repeat (8) @(posedge ref_clk);
    end
    settle();
    chk(40'(div_disp_out), 40'((DIV_EDGES / 8) % 32));
    chk(40'(div_blink_out), 40'((DIV_EDGES / 4096) % 8));
    $display("divider test done");
    // Divider now holds 4232: tap bit 4 low, blink bit 12 high
    wr(`SLD_REG_CTRL, 32'h06);
    settle();
    chk(segment_out, ~PAT_A);
    blink_enable_n <= 1'b0;
    blink_clock_in <= 1'b0;
    wr(`SLD_REG_CTRL, 32'h26);
    settle();
    chk(segment_out, {40{1'b1}});
    rd(`SLD_REG_CTRL, 32'h26);
    $display("clock select test done");
    tally_and_finish();
  end
endmodule
